//--- logic/mcsk_alu.sv
// arithmetic and test core: one operation evaluated combinationally
`timescale 1ns/1ps
`default_nettype none
`include "mcsk_defines.svh"

module mcsk_alu
    import mcsk_pkg::*;
(
    input wire mcsk_op_e op_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] mem_i,
    input wire logic [7:0] imm_i,
    input wire logic [2:0] bit_i,
    input wire logic [15:0] prog_i,
    input wire mcsk_flags_s flags_i,
    output mcsk_alu_s res_o
);

    logic [7:0] sub_b;
    logic [8:0] diff;
    logic [4:0] nib;
    logic [7:0] dec_v;
    logic [7:0] inc_v;
    logic [7:0] xor_v;
    logic [7:0] swap_v;
    logic [7:0] bit_mask;

    // shared datapath terms
    assign sub_b = (op_i == OP_SUBTRACT_IMM) ? imm_i : mem_i;
    assign diff = {1'b0, acc_i} - {1'b0, sub_b};
    assign nib = {1'b0, acc_i[3:0]} - {1'b0, sub_b[3:0]};
    assign dec_v = mem_i - `MCSK_BYTE_ONE;
    assign inc_v = mem_i + `MCSK_BYTE_ONE;
    assign xor_v = acc_i ^ ((op_i == OP_EXCLUSIVE_OR_IMM) ? imm_i : mem_i);
    assign swap_v = {mem_i[3:0], mem_i[7:4]};
    assign bit_mask = `MCSK_BYTE_ONE << bit_i;

    // default result writes nothing and keeps the flags
    always_comb begin
        res_o = '0;
        res_o.flags = flags_i;
        res_o.table_high_byte_latch_val = prog_i[15:8];
        unique case (op_i)
            OP_DEC_SKIP_IF_ZERO: begin
                res_o.mem_val = dec_v;
                res_o.mem_wr = 1'b1;
                res_o.skip_op = 1'b1;
                res_o.skip = (dec_v == `MCSK_BYTE_ZERO);
            end
            OP_DEC_TO_ACC_SKIP_IF_ZERO: begin
                res_o.acc_val = dec_v;
                res_o.acc_wr = 1'b1;
                res_o.skip_op = 1'b1;
                res_o.skip = (dec_v == `MCSK_BYTE_ZERO);
            end
            OP_INC_SKIP_IF_ZERO: begin
                res_o.mem_val = inc_v;
                res_o.mem_wr = 1'b1;
                res_o.skip_op = 1'b1;
                res_o.skip = (inc_v == `MCSK_BYTE_ZERO);
            end
            OP_INC_TO_ACC_SKIP_IF_ZERO: begin
                res_o.acc_val = inc_v;
                res_o.acc_wr = 1'b1;
                res_o.skip_op = 1'b1;
                res_o.skip = (inc_v == `MCSK_BYTE_ZERO);
            end
            OP_SET_BYTE: begin
                res_o.mem_val = `MCSK_BYTE_ONES;
                res_o.mem_wr = 1'b1;
            end
            OP_SET_BIT: begin
                res_o.mem_val = mem_i | bit_mask;
                res_o.mem_wr = 1'b1;
            end
            OP_SUBTRACT, OP_SUBTRACT_TO_MEMORY, OP_SUBTRACT_IMM: begin
                res_o.mem_val = diff[7:0];
                res_o.acc_val = diff[7:0];
                res_o.mem_wr = (op_i == OP_SUBTRACT_TO_MEMORY);
                res_o.acc_wr = (op_i != OP_SUBTRACT_TO_MEMORY);
                res_o.flags.carry = ~diff[8]; // not-borrow
                res_o.flags.half_carry_flag = ~nib[4];
                res_o.flags.zero = (diff[7:0] == `MCSK_BYTE_ZERO);
                res_o.flags.signed_range_flag = (acc_i[7] ^ sub_b[7]) & (diff[7] ^ acc_i[7]);
            end
            OP_NIBBLE_EXCHANGE: begin
                res_o.mem_val = swap_v;
                res_o.mem_wr = 1'b1;
            end
            OP_NIBBLE_EXCHANGE_TO_ACC: begin
                res_o.acc_val = swap_v;
                res_o.acc_wr = 1'b1;
            end
            OP_SKIP_IF_ZERO: begin
                res_o.skip_op = 1'b1;
                res_o.skip = (mem_i == `MCSK_BYTE_ZERO);
            end
            OP_MOVE_SKIP_IF_ZERO: begin
                res_o.acc_val = mem_i;
                res_o.acc_wr = 1'b1;
                res_o.skip_op = 1'b1;
                res_o.skip = (mem_i == `MCSK_BYTE_ZERO);
            end
            OP_SKIP_IF_BIT_ZERO: begin
                res_o.skip_op = 1'b1;
                res_o.skip = ~mem_i[bit_i];
            end
            OP_SKIP_IF_BIT_ONE: begin
                res_o.skip_op = 1'b1;
                res_o.skip = mem_i[bit_i];
            end
            OP_TABLE_READ, OP_LAST_PAGE_TABLE_READ: begin
                res_o.mem_val = prog_i[7:0];
                res_o.mem_wr = 1'b1;
                res_o.table_high_byte_latch_wr = 1'b1;
            end
            OP_EXCLUSIVE_OR, OP_EXCLUSIVE_OR_TO_MEMORY, OP_EXCLUSIVE_OR_IMM: begin
                res_o.mem_val = xor_v;
                res_o.acc_val = xor_v;
                res_o.mem_wr = (op_i == OP_EXCLUSIVE_OR_TO_MEMORY);
                res_o.acc_wr = (op_i != OP_EXCLUSIVE_OR_TO_MEMORY);
                res_o.flags.zero = (xor_v == `MCSK_BYTE_ZERO);
            end
            default: begin
                // no operation, also for unused codes
            end
        endcase
    end

endmodule // mcsk_alu
`default_nettype wire

//--- logic/mcsk_defines.svh
// register offsets, field positions and constant values of the skip/subtract unit
`ifndef MCSK_DEFINES_SVH
`define MCSK_DEFINES_SVH

// wishbone byte offsets, one aligned word each
`define MCSK_OFF_CTRL 8'h00
`define MCSK_OFF_ADDR 8'h04
`define MCSK_OFF_IMM 8'h08
`define MCSK_OFF_ACC 8'h0C
`define MCSK_OFF_STAT 8'h10
`define MCSK_OFF_TABLE_POINTER_LOWER 8'h14
`define MCSK_OFF_TABLE_POINTER_UPPER 8'h18
`define MCSK_OFF_TABLE_HIGH_BYTE_LATCH 8'h1C
`define MCSK_OFF_PC 8'h20
`define MCSK_OFF_MEMD 8'h24
`define MCSK_OFF_PROG 8'h28

// control word fields
`define MCSK_CTRL_OP_LSB 0
`define MCSK_CTRL_OP_MSB 4
`define MCSK_CTRL_BIT_LSB 8
`define MCSK_CTRL_BIT_MSB 10

// status word fields (flags occupy bits 3..0)
`define MCSK_STAT_FLG_MSB 3
`define MCSK_STAT_SKIP 4

// data values
`define MCSK_BYTE_ZERO 8'h00
`define MCSK_BYTE_ONES 8'hFF
`define MCSK_BYTE_ONE 8'h01
`define MCSK_WORD_ZERO 32'h0000_0000
`define MCSK_FLAGS_RST 4'h0

`endif

//--- logic/mcsk_exec_unit.sv
// execution unit for skip, set, subtract, swap, table read and xor operations
//
// Implementation choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mcsk_defines.svh"

// Summary of operation
// - decrement-and-skip writes operand minus one to memory, skips when it is zero
// - decrement-to-accumulator skip loads operand minus one, memory and flags kept
// - increment-and-skip writes operand plus one to memory, skips on zero, flags kept
// - increment-to-accumulator skip loads operand plus one, memory kept, skips on zero
// - every conditional skip takes two cycles; failing condition continues normally
// - byte set writes all ones into the memory byte, flags kept
// - bit set forces only the chosen bit to one, flags kept
// - subtract memory from accumulator into accumulator, updating four arithmetic flags
// - subtraction carry is not-borrow: zero when negative, one otherwise
// - subtract-to-memory writes accumulator minus memory back to memory, four flags
// - immediate subtract puts accumulator minus immediate in accumulator, four flags
// - nibble exchange swaps the two halves of the memory byte in place
// - nibble exchange to accumulator loads swapped byte, memory and flags kept
// - byte-zero test skips when memory byte is zero, changing nothing
// - move-and-skip copies memory byte to accumulator, skips when it is zero
// - bit-clear test skips when the chosen memory bit is zero
// - bit-set test skips when the chosen memory bit is one, flags kept
// - table read fetches word at both pointers: low byte to memory, high to latch
// - last-page table read uses only the lower pointer within the top page
// - xor with memory leaves result in accumulator, updating only zero flag
// - xor to memory writes result back to memory, updating only zero flag
// - xor with immediate replaces the accumulator with the result
module mcsk_exec_unit
    import mcsk_pkg::*;
#(
    parameter int DM_AW = 8,
    parameter int PM_AW = 10
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    // storage arrays
    logic [7:0] dmem [0:(1 << DM_AW) - 1];
    logic [15:0] pmem [0:(1 << PM_AW) - 1];

    mcsk_state_e state_reg;
    mcsk_op_e op_reg;
    logic [2:0] bit_reg;
    logic [DM_AW-1:0] addr_reg;
    logic [7:0] imm_reg;
    logic [7:0] acc_reg;
    mcsk_flags_s flags_reg;
    logic skip_reg;
    logic [PM_AW-1:0] pc_reg;
    logic [7:0] table_pointer_lower_reg;
    logic [7:0] table_pointer_upper_reg;
    logic [7:0] table_high_byte_latch_reg;
    logic [31:0] rd_next;

    logic req;
    logic wr;
    logic exec;
    logic start;
    logic discard;
    logic [7:0] mem_rd;
    logic [15:0] tbl_full;
    logic [PM_AW-1:0] prog_addr;
    logic [15:0] prog_rd;
    mcsk_alu_s alu;

    // requests are only taken while idle, which keeps bus writes and
    // execution writes to the same storage from ever colliding
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & (state_reg == ST_IDLE);
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign start = wr & (wb_adr_i == `MCSK_OFF_CTRL);
    assign discard = start & skip_reg;
    assign exec = (state_reg == ST_EXEC);

    // operand fetch and table address; the last page is the top one
    assign mem_rd = dmem[addr_reg];
    assign tbl_full = {table_pointer_upper_reg, table_pointer_lower_reg};
    assign prog_addr = (op_reg == OP_LAST_PAGE_TABLE_READ) ?
        {{(PM_AW - 8){1'b1}}, table_pointer_lower_reg} : tbl_full[PM_AW-1:0];
    assign prog_rd = pmem[prog_addr];

    mcsk_alu u_alu (
        .op_i(op_reg),
        .acc_i(acc_reg),
        .mem_i(mem_rd),
        .imm_i(imm_reg),
        .bit_i(bit_reg),
        .prog_i(prog_rd),
        .flags_i(flags_reg),
        .res_o(alu)
    );

    // sequencer: skip-type operations spend a second, dummy cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (start && !skip_reg) begin
                        state_reg <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state_reg <= alu.skip_op ? ST_DUMMY : ST_IDLE;
                end
                ST_DUMMY: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // operation latch; unused codes fall through as no operation
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            op_reg <= OP_NOP;
            bit_reg <= 3'h0;
        end else if (start && !skip_reg) begin
            op_reg <= mcsk_op_e'(wb_dat_i[`MCSK_CTRL_OP_MSB:`MCSK_CTRL_OP_LSB]);
            bit_reg <= wb_dat_i[`MCSK_CTRL_BIT_MSB:`MCSK_CTRL_BIT_LSB];
        end
    end

    // skip pending: set by a taken skip, consumed by the next operation
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            skip_reg <= 1'b0;
        end else if (exec && alu.skip_op) begin
            skip_reg <= alu.skip;
        end else if (discard) begin
            skip_reg <= 1'b0;
        end
    end

    // program counter: one step per executed or discarded operation
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_reg <= '0;
        end else if (exec || discard) begin
            pc_reg <= pc_reg + 1'b1;
        end
    end

    // operand address and immediate
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_reg <= '0;
            imm_reg <= `MCSK_BYTE_ZERO;
        end else if (wr && wb_adr_i == `MCSK_OFF_ADDR) begin
            addr_reg <= wb_dat_i[DM_AW-1:0];
        end else if (wr && wb_adr_i == `MCSK_OFF_IMM) begin
            imm_reg <= wb_dat_i[7:0];
        end
    end

    // accumulator: written by software or by the operation
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_reg <= `MCSK_BYTE_ZERO;
        end else if (exec && alu.acc_wr) begin
            acc_reg <= alu.acc_val;
        end else if (wr && wb_adr_i == `MCSK_OFF_ACC) begin
            acc_reg <= wb_dat_i[7:0];
        end
    end

    // flags: operations that leave them alone hand back the old value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_reg <= `MCSK_FLAGS_RST;
        end else if (exec) begin
            flags_reg <= alu.flags;
        end else if (wr && wb_adr_i == `MCSK_OFF_STAT) begin
            flags_reg <= wb_dat_i[`MCSK_STAT_FLG_MSB:0];
        end
    end

    // table pointers and high-byte latch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            table_pointer_lower_reg <= `MCSK_BYTE_ZERO;
            table_pointer_upper_reg <= `MCSK_BYTE_ZERO;
            table_high_byte_latch_reg <= `MCSK_BYTE_ZERO;
        end else begin
            if (exec && alu.table_high_byte_latch_wr) begin
                table_high_byte_latch_reg <= alu.table_high_byte_latch_val;
            end
            if (wr && wb_adr_i == `MCSK_OFF_TABLE_POINTER_LOWER) begin
                table_pointer_lower_reg <= wb_dat_i[7:0];
            end
            if (wr && wb_adr_i == `MCSK_OFF_TABLE_POINTER_UPPER) begin
                table_pointer_upper_reg <= wb_dat_i[7:0];
            end
        end
    end

    // data memory; contents are not reset
    always_ff @(posedge clk_i) begin
        if (exec && alu.mem_wr) begin
            dmem[addr_reg] <= alu.mem_val;
        end else if (wr && wb_adr_i == `MCSK_OFF_MEMD) begin
            dmem[addr_reg] <= wb_dat_i[7:0];
        end
    end

    // program memory is loaded by software at the full table address
    always_ff @(posedge clk_i) begin
        if (wr && wb_sel_i[1] && wb_adr_i == `MCSK_OFF_PROG) begin
            pmem[tbl_full[PM_AW-1:0]] <= wb_dat_i[15:0];
        end
    end

    // read mux; unmapped offsets read as zero
    always_comb begin
        rd_next = `MCSK_WORD_ZERO;
        unique case (wb_adr_i)
            `MCSK_OFF_CTRL: begin
                rd_next[`MCSK_CTRL_OP_MSB:`MCSK_CTRL_OP_LSB] = op_reg;
                rd_next[`MCSK_CTRL_BIT_MSB:`MCSK_CTRL_BIT_LSB] = bit_reg;
            end
            `MCSK_OFF_ADDR: rd_next[DM_AW-1:0] = addr_reg;
            `MCSK_OFF_IMM: rd_next[7:0] = imm_reg;
            `MCSK_OFF_ACC: rd_next[7:0] = acc_reg;
            `MCSK_OFF_STAT: begin
                rd_next[`MCSK_STAT_FLG_MSB:0] = flags_reg;
                rd_next[`MCSK_STAT_SKIP] = skip_reg;
            end
            `MCSK_OFF_TABLE_POINTER_LOWER: rd_next[7:0] = table_pointer_lower_reg;
            `MCSK_OFF_TABLE_POINTER_UPPER: rd_next[7:0] = table_pointer_upper_reg;
            `MCSK_OFF_TABLE_HIGH_BYTE_LATCH: rd_next[7:0] = table_high_byte_latch_reg;
            `MCSK_OFF_PC: rd_next[PM_AW-1:0] = pc_reg;
            `MCSK_OFF_MEMD: rd_next[7:0] = mem_rd;
            `MCSK_OFF_PROG: rd_next[15:0] = pmem[tbl_full[PM_AW-1:0]];
            default: begin
            end
        endcase
    end

    // wishbone answer: one cycle after the request, held back while busy
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `MCSK_WORD_ZERO;
        end else begin
            wb_ack_o <= req;
            if (req && !wb_we_i) begin
                wb_dat_o <= rd_next;
            end
        end
    end

    // checks on the execution behaviour
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_dummy_then_idle;
        state_reg == ST_DUMMY ##1 state_reg == ST_IDLE;
    endsequence

    sequence s_exec_of(mcsk_op_e op);
        exec && op_reg == op;
    endsequence

    a_dec_mem_write: assert property (
        s_exec_of(OP_DEC_SKIP_IF_ZERO) |=>
            mem_rd == $past(mem_rd) - `MCSK_BYTE_ONE && skip_reg == (mem_rd == `MCSK_BYTE_ZERO))
        else $error("decrement-and-skip result or skip wrong");

    a_skip_two_cycles: assert property (
        exec && alu.skip_op |=> s_dummy_then_idle)
        else $error("skip operation did not take two cycles");

    a_sub_not_borrow: assert property (
        exec && (op_reg == OP_SUBTRACT || op_reg == OP_SUBTRACT_TO_MEMORY) |=>
            flags_reg.carry == ($past(acc_reg) >= $past(mem_rd)))
        else $error("subtract carry is not the not-borrow");

    a_set_byte_ones: assert property (
        s_exec_of(OP_SET_BYTE) |=> mem_rd == `MCSK_BYTE_ONES && $stable(flags_reg))
        else $error("byte set did not write all ones");

    a_skip_discard_nop: assert property (
        discard |=> state_reg == ST_IDLE && !skip_reg && $stable(acc_reg)
            && $stable(flags_reg) && pc_reg == $past(pc_reg) + 1'b1)
        else $error("discarded operation changed state");

    a_xor_zero_only: assert property (
        s_exec_of(OP_EXCLUSIVE_OR) |=> acc_reg == ($past(acc_reg) ^ $past(mem_rd))
            && flags_reg.zero == (acc_reg == `MCSK_BYTE_ZERO)
            && flags_reg.carry == $past(flags_reg.carry)
            && flags_reg.signed_range_flag == $past(flags_reg.signed_range_flag))
        else $error("xor result or flags wrong");

    a_swap_acc_value: assert property (
        s_exec_of(OP_NIBBLE_EXCHANGE_TO_ACC) |=>
            acc_reg == {$past(mem_rd[3:0]), $past(mem_rd[7:4])} && $stable(mem_rd))
        else $error("nibble exchange to accumulator wrong");

    a_table_high_latch: assert property (
        s_exec_of(OP_TABLE_READ) |=>
            table_high_byte_latch_reg == $past(prog_rd[15:8]) && mem_rd == $past(prog_rd[7:0]))
        else $error("table read did not split the word");

    a_inc_acc_keep: assert property (
        s_exec_of(OP_INC_TO_ACC_SKIP_IF_ZERO) |=>
            acc_reg == $past(mem_rd) + `MCSK_BYTE_ONE && $stable(mem_rd) ##1 !exec)
        else $error("increment to accumulator wrong");

    // the accumulator variant of decrement must leave memory and flags alone
    a_dec_acc_keep: assert property (
        s_exec_of(OP_DEC_TO_ACC_SKIP_IF_ZERO) |=> acc_reg == $past(mem_rd) - `MCSK_BYTE_ONE
            && $stable(mem_rd) && $stable(flags_reg))
        else $error("decrement to accumulator wrong");

    a_set_bit_only: assert property (
        s_exec_of(OP_SET_BIT) |=> mem_rd == ($past(mem_rd) | (`MCSK_BYTE_ONE << $past(bit_reg)))
            && $stable(flags_reg))
        else $error("bit set touched more than one bit");

    a_sub_mem_result: assert property (
        s_exec_of(OP_SUBTRACT_TO_MEMORY) |=> mem_rd == $past(acc_reg) - $past(mem_rd)
            && $stable(acc_reg))
        else $error("subtract to memory result wrong");

    a_zero_test_keeps: assert property (
        s_exec_of(OP_SKIP_IF_ZERO) |=> skip_reg == ($past(mem_rd) == `MCSK_BYTE_ZERO)
            && $stable(acc_reg) && $stable(mem_rd) && $stable(flags_reg))
        else $error("byte-zero test decision or side effect wrong");

    // both bit tests read the bit chosen when the operation was started
    a_bit_zero_skip: assert property (
        s_exec_of(OP_SKIP_IF_BIT_ZERO) |=> skip_reg == !$past(mem_rd[bit_reg]))
        else $error("bit-zero test decision wrong");

    a_bit_one_skip: assert property (
        s_exec_of(OP_SKIP_IF_BIT_ONE) |=> skip_reg == $past(mem_rd[bit_reg])
            && $stable(flags_reg))
        else $error("bit-one test decision wrong");

endmodule // mcsk_exec_unit
`default_nettype wire

//--- logic/mcsk_pkg.sv
// types shared by the skip/subtract execution unit and its arithmetic core
`default_nettype none
package mcsk_pkg;

    // operation codes written into the control register
    typedef enum logic [4:0] {
        OP_NOP,
        OP_DEC_SKIP_IF_ZERO,
        OP_DEC_TO_ACC_SKIP_IF_ZERO,
        OP_INC_SKIP_IF_ZERO,
        OP_INC_TO_ACC_SKIP_IF_ZERO,
        OP_SET_BYTE,
        OP_SET_BIT,
        OP_SUBTRACT,
        OP_SUBTRACT_TO_MEMORY,
        OP_SUBTRACT_IMM,
        OP_NIBBLE_EXCHANGE,
        OP_NIBBLE_EXCHANGE_TO_ACC,
        OP_SKIP_IF_ZERO,
        OP_MOVE_SKIP_IF_ZERO,
        OP_SKIP_IF_BIT_ZERO,
        OP_SKIP_IF_BIT_ONE,
        OP_TABLE_READ,
        OP_LAST_PAGE_TABLE_READ,
        OP_EXCLUSIVE_OR,
        OP_EXCLUSIVE_OR_TO_MEMORY,
        OP_EXCLUSIVE_OR_IMM
    } mcsk_op_e;

    typedef enum {ST_IDLE, ST_EXEC, ST_DUMMY} mcsk_state_e;

    // status flags, bit 3 down to bit 0
    typedef struct packed {
        logic carry;
        logic half_carry_flag;
        logic zero;
        logic signed_range_flag;
    } mcsk_flags_s;

    // everything one operation produces
    typedef struct packed {
        logic [7:0] mem_val;
        logic mem_wr;
        logic [7:0] acc_val;
        logic acc_wr;
        mcsk_flags_s flags;
        logic [7:0] table_high_byte_latch_val;
        logic table_high_byte_latch_wr;
        logic skip_op;
        logic skip;
    } mcsk_alu_s;

endpackage
`default_nettype wire

//--- test/mcsk_exec_unit_test.sv
// self-checking bench for the skip/subtract execution unit
`timescale 1ns/1ps
`default_nettype none
`include "mcsk_defines.svh"

module mcsk_exec_unit_test;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    int err_total = 0;
    int check_count = 0;
    int seed = 32'hFF34A265;
    // reference state of the unit
    logic [7:0] acc_m, mem_m, imm_m, lo_m, up_m;
    logic [7:0] table_high_byte_latch_m = 8'h00;
    logic [3:0] fl_m;
    logic skp_m = 1'b0;
    logic [31:0] pc_m = 32'h0;
    logic [15:0] prog_m [int];

    mcsk_exec_unit #(.DM_AW(8), .PM_AW(10)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

    // 40 MHz clock
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // classic single cycle; the unit stalls ack while an operation executes,
    // and a bus that never answers is left to the watchdog
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                           output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] q;
        wb_xfer(1'b1, adr, dat, q);
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rdchk(input string name, input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] q;
        wb_xfer(1'b0, adr, 32'h0, q);
        chk(name, exp, q);
    endtask

    // reference behaviour of one control write
    task automatic model(input int op, input logic [2:0] b);
        logic [8:0] d;
        logic [7:0] o;
        pc_m++;
        if (skp_m) begin
            skp_m = 1'b0;
            return;
        end
        o = (op == 9 || op == 20) ? imm_m : mem_m;
        d = {1'b0, acc_m} - {1'b0, o};
        case (op)
            0, 21, 22, 23: begin
                // no operation: only the counter moves
            end
            1: begin
                mem_m = mem_m - 8'h01;
                skp_m = (mem_m == 8'h00);
            end
            2: begin
                acc_m = mem_m - 8'h01;
                skp_m = (acc_m == 8'h00);
            end
            3: begin
                mem_m = mem_m + 8'h01;
                skp_m = (mem_m == 8'h00);
            end
            4: begin
                acc_m = mem_m + 8'h01;
                skp_m = (acc_m == 8'h00);
            end
            5: mem_m = 8'hFF;
            6: mem_m[b] = 1'b1;
            7, 8, 9: begin
                fl_m = {acc_m >= o, acc_m[3:0] >= o[3:0], d[7:0] == 8'h00,
                        (acc_m[7] != o[7]) && (d[7] != acc_m[7])};
                if (op == 8) begin
                    mem_m = d[7:0];
                end else begin
                    acc_m = d[7:0];
                end
            end
            10: mem_m = {mem_m[3:0], mem_m[7:4]};
            11: acc_m = {mem_m[3:0], mem_m[7:4]};
            12: skp_m = (mem_m == 8'h00);
            13: begin
                acc_m = mem_m;
                skp_m = (mem_m == 8'h00);
            end
            14: skp_m = !mem_m[b];
            15: skp_m = mem_m[b];
            16: {table_high_byte_latch_m, mem_m} = prog_m[{up_m[1:0], lo_m}];
            17: {table_high_byte_latch_m, mem_m} = prog_m[{2'b11, lo_m}];
            default: begin
                o = acc_m ^ o;
                fl_m[1] = (o == 8'h00);
                if (op == 19) begin
                    mem_m = o;
                end else begin
                    acc_m = o;
                end
            end
        endcase
    endtask

    // watchdog: a full run needs well under 20000 cycles
    initial begin
        repeat (50000) @(posedge clk_i);
        err_total++;
        stop_test();
    end

    initial begin
        logic [31:0] r, s;
        logic [2:0] b;
        int op;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk("acc", `MCSK_OFF_ACC, 32'h0);
        rdchk("stat", `MCSK_OFF_STAT, 32'h0);
        rdchk("unmapped", 8'h30, 32'h0);
        wr(`MCSK_OFF_PC, 32'h5A); // read-only, must be ignored
        rdchk("pc", `MCSK_OFF_PC, 32'h0);
        // a write without byte lane 0 is acknowledged but must change nothing
        wb_sel_i <= 4'hE;
        wr(`MCSK_OFF_ACC, 32'h5A);
        wb_sel_i <= 4'hF;
        rdchk("acc lane", `MCSK_OFF_ACC, 32'h0);
        // random operands biased toward zero results so skips are taken often
        for (int i = 0; i < 200; i++) begin
            r = $random(seed);
            s = $random(seed);
            mem_m = r[10] ? r[7:0] : ({8{r[3]}} ^ {7'h0, r[2]});
            acc_m = r[11] ? mem_m : r[19:12];
            imm_m = r[12] ? acc_m : r[27:20];
            fl_m = r[31:28];
            b = s[10:8];
            lo_m = s[7:0];
            up_m = {6'h0, s[12:11]};
            op = $unsigned(s) % 24; // also the idle code and some unused ones
            wr(`MCSK_OFF_ADDR, {24'h0, r[27:20]});
            wr(`MCSK_OFF_MEMD, {24'h0, mem_m});
            wr(`MCSK_OFF_ACC, {24'h0, acc_m});
            wr(`MCSK_OFF_IMM, {24'h0, imm_m});
            wr(`MCSK_OFF_STAT, {28'h0, fl_m});
            wr(`MCSK_OFF_TABLE_POINTER_LOWER, {24'h0, lo_m});
            wr(`MCSK_OFF_TABLE_POINTER_UPPER, 32'h3);
            wr(`MCSK_OFF_PROG, {16'h0, s[31:16]});
            prog_m[{2'b11, lo_m}] = s[31:16];
            wr(`MCSK_OFF_TABLE_POINTER_UPPER, {24'h0, up_m});
            wr(`MCSK_OFF_PROG, {16'h0, r[15:0]});
            prog_m[{up_m[1:0], lo_m}] = r[15:0];
            wr(`MCSK_OFF_CTRL, {21'h0, b, 3'h0, op[4:0]});
            model(op, b);
            rdchk("acc", `MCSK_OFF_ACC, {24'h0, acc_m});
            rdchk("acc", `MCSK_OFF_ACC, {24'h0, acc_m});
            rdchk("stat", `MCSK_OFF_STAT, {27'h0, skp_m, fl_m});
            rdchk("memd", `MCSK_OFF_MEMD, {24'h0, mem_m});
            rdchk("memd", `MCSK_OFF_MEMD, {24'h0, mem_m});
            rdchk("table_high_byte_latch", `MCSK_OFF_TABLE_HIGH_BYTE_LATCH, {24'h0, table_high_byte_latch_m});
            rdchk("pc", `MCSK_OFF_PC, pc_m);
        end
        stop_test();
    end
endmodule // mcsk_exec_unit_test
`default_nettype wire
